//--- atsp_top.sv
// Purpose: async terminal serial port, register side and channels
// Assumes: caller decodes the device base, gives the low 3 bits
// Notes: read answers one cycle after the read strobe
`timescale 1ns/100ps
`include "atsp_params.svh"
module atsp_top #(
  parameter int BIT_CYCLES = `ATSP_BIT_CYCLES,
  parameter logic [7:0] IDENT_CODE = 8'h2a // arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] iox_addr_in,
  input wire logic iox_rd_in,
  input wire logic iox_wr_in,
  input wire logic [15:0] iox_wdata_in,
  output logic [15:0] iox_rdata_out,
  input wire logic console_monitor_mode_in,
  input wire logic test_mode_group_in,
  output logic test_mode_out,
  input wire logic rxd_in,
  output logic txd_out,
  output logic irq_lvl12_out,
  output logic irq_lvl10_out,
  output logic [7:0] ident_code_out
);
  import atsp_pkg::*;

  localparam int HALF = BIT_CYCLES / 2; // half-bit timer
  // reset value of both control words, named so its fields can be picked
  localparam logic [15:0] CTRL_RST = `ATSP_CTRL_RST;

  // strobes decoded per offset
  logic rd_data; // read of receive data
  logic wr_in_ctrl; // write of input control
  logic wr_tx; // write of transmit data
  logic wr_out_ctrl; // write of output control

  // input control word fields
  logic ie_in_r, ie_in_nxt; // receive interrupt enable
  logic test_r, test_nxt; // loopback test
  atsp_len_t len_r, len_nxt; // character length code
  logic stop1_r, stop1_nxt; // one stop bit
  logic par_en_r, par_en_nxt; // parity on
  // output control word
  logic ie_out_r, ie_out_nxt; // transmit interrupt enable

  // receive side state
  logic [7:0] rx_data_r, rx_data_nxt; // last character
  logic avail_r, avail_nxt; // character waiting
  logic frm_r, frm_nxt; // framing error
  logic par_r, par_nxt; // parity error
  logic ovr_r, ovr_nxt; // overrun

  // transmit holding buffer
  logic [7:0] hold_r, hold_nxt;
  logic full_r, full_nxt;

  // read answer
  logic [15:0] rdata_r, rdata_nxt;

  // receiver outputs
  logic rx_done; // one-cycle pulse per character
  logic [7:0] rx_char; // masked character
  logic rx_frm; // stop bit missing
  logic rx_par; // odd parity seen

  // transmitter handshake
  logic tx_ready; // sender idle
  logic tx_take; // holding moves to sender
  logic txd; // serial out
  logic rx_line; // what the receiver hears
  logic test_any; // own or group test

  // status words as seen by a read
  logic [15:0] stat_in;
  logic [15:0] stat_out;

  // shared character format
  atsp_cfg_if cfg_if ();

  assign cfg_if.len = len_r;
  assign cfg_if.stop1 = stop1_r;
  assign cfg_if.par_en = par_en_r;

  // offset decode; writes to read-only offsets are dropped
  assign rd_data = iox_rd_in && (iox_addr_in == `ATSP_OFF_RX_DATA);
  assign wr_in_ctrl = iox_wr_in && (iox_addr_in == `ATSP_OFF_IN_CTRL);
  assign wr_tx = iox_wr_in && (iox_addr_in == `ATSP_OFF_TX_DATA);
  assign wr_out_ctrl = iox_wr_in && (iox_addr_in == `ATSP_OFF_OUT_CTRL);

  // test mode from any interface of the group loops us too
  assign test_any = test_r | test_mode_group_in;
  assign test_mode_out = test_r;
  // loopback keeps driving the line so a terminal still sees it
  assign rx_line = test_any ? txd : rxd_in;
  assign txd_out = txd;

  // input status word
  always_comb begin
    stat_in = 16'h0000;
    stat_in[`ATSP_B_IE] = ie_in_r;
    stat_in[`ATSP_B_RDY] = avail_r & ~console_monitor_mode_in;
    stat_in[`ATSP_B_FRM] = frm_r;
    stat_in[`ATSP_B_PAR] = par_r;
    stat_in[`ATSP_B_OVR] = ovr_r;
    stat_in[`ATSP_B_ERR] = frm_r | par_r | ovr_r;
  end

  // output status word
  always_comb begin
    stat_out = 16'h0000;
    stat_out[`ATSP_B_IE] = ie_out_r;
    stat_out[`ATSP_B_RDY] = ~full_r;
  end

  // interrupt requests, one per channel level
  assign irq_lvl12_out = stat_in[`ATSP_B_RDY] & ie_in_r;
  assign irq_lvl10_out = stat_out[`ATSP_B_RDY] & ie_out_r;
  // one ident serves both channels
  assign ident_code_out = IDENT_CODE;

  // control words: next values
  always_comb begin
    ie_in_nxt = ie_in_r;
    test_nxt = test_r;
    len_nxt = len_r;
    stop1_nxt = stop1_r;
    par_en_nxt = par_en_r;
    ie_out_nxt = ie_out_r;
    if (wr_in_ctrl) begin
      ie_in_nxt = iox_wdata_in[`ATSP_B_IE];
      test_nxt = iox_wdata_in[`ATSP_B_TEST];
      len_nxt = iox_wdata_in[`ATSP_B_LEN_HI:`ATSP_B_LEN_LO];
      stop1_nxt = iox_wdata_in[`ATSP_B_STOP1];
      par_en_nxt = iox_wdata_in[`ATSP_B_PAR_EN];
    end
    if (wr_out_ctrl) begin
      ie_out_nxt = iox_wdata_in[`ATSP_B_IE];
    end
  end

  // control words: registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ie_in_r <= CTRL_RST[`ATSP_B_IE];
      test_r <= CTRL_RST[`ATSP_B_TEST];
      len_r <= CTRL_RST[`ATSP_B_LEN_HI:`ATSP_B_LEN_LO];
      stop1_r <= CTRL_RST[`ATSP_B_STOP1];
      par_en_r <= CTRL_RST[`ATSP_B_PAR_EN];
      ie_out_r <= CTRL_RST[`ATSP_B_IE];
    end else begin
      ie_in_r <= ie_in_nxt;
      test_r <= test_nxt;
      len_r <= len_nxt;
      stop1_r <= stop1_nxt;
      par_en_r <= par_en_nxt;
      ie_out_r <= ie_out_nxt;
    end
  end

  // receive buffer: a new character wins over a clearing read
  always_comb begin
    rx_data_nxt = rx_data_r;
    avail_nxt = avail_r;
    frm_nxt = frm_r;
    par_nxt = par_r;
    ovr_nxt = ovr_r;
    // monitor mode reads leave the flag alone
    if (rd_data && !console_monitor_mode_in) begin
      avail_nxt = 1'b0;
      ovr_nxt = 1'b0;
    end
    if (rx_done) begin
      rx_data_nxt = rx_char;
      avail_nxt = 1'b1;
      frm_nxt = rx_frm;
      par_nxt = rx_par;
      // unread character overwritten, unless read this cycle
      if (avail_r && !(rd_data && !console_monitor_mode_in)) begin
        ovr_nxt = 1'b1;
      end
    end
  end

  // receive buffer: registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_data_r <= 8'h00;
      avail_r <= 1'b0;
      frm_r <= 1'b0;
      par_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      rx_data_r <= rx_data_nxt;
      avail_r <= avail_nxt;
      frm_r <= frm_nxt;
      par_r <= par_nxt;
      ovr_r <= ovr_nxt;
    end
  end

  // holding buffer; a write while full is ignored
  assign tx_take = full_r & tx_ready;
  always_comb begin
    hold_nxt = hold_r;
    full_nxt = full_r;
    if (tx_take) begin
      full_nxt = 1'b0;
    end
    if (wr_tx && !full_r) begin
      hold_nxt = iox_wdata_in[7:0];
      full_nxt = 1'b1;
    end
  end

  // holding buffer: registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_r <= 8'h00;
      full_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      full_r <= full_nxt;
    end
  end

  // read mux, registered; unmapped offsets read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (iox_rd_in) begin
      case (iox_addr_in)
        `ATSP_OFF_RX_DATA: rdata_nxt = {8'h00, rx_data_r};
        `ATSP_OFF_IN_STAT: rdata_nxt = stat_in;
        `ATSP_OFF_OUT_STAT: rdata_nxt = stat_out;
        `ATSP_OFF_ZERO: rdata_nxt = 16'h0000;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // read answer register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign iox_rdata_out = rdata_r;

  // receiver: hears the line or the looped transmitter
  atsp_rx #(
    .HALF(HALF),
    .FULL(BIT_CYCLES)
  ) u_rx (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cfg(cfg_if.dst),
    .rxd_in(rx_line),
    .done_out(rx_done),
    .data_out(rx_char),
    .frm_err_out(rx_frm),
    .par_err_out(rx_par)
  );

  // transmitter: same format as the receiver
  atsp_tx #(
    .HALF(HALF)
  ) u_tx (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cfg(cfg_if.dst),
    .valid_in(full_r),
    .data_in(hold_r),
    .ready_out(tx_ready),
    .txd_out(txd)
  );

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_clr_rd;
    rd_data && !console_monitor_mode_in && !rx_done;
  endsequence
  sequence s_load;
    wr_tx && !full_r && tx_ready;
  endsequence

  property p_rd_data;
    rd_data |=> iox_rdata_out == {8'h00, $past(rx_data_r)};
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("data read wrong");
  property p_rd_clear;
    s_clr_rd |=> !avail_r && !stat_in[`ATSP_B_RDY];
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("avail not cleared");
  property p_mon_keep;
    rd_data && console_monitor_mode_in && avail_r |=> avail_r;
  endproperty
  a_mon_keep: assert property (p_mon_keep) else $error("monitor read cleared");
  property p_mon_hide;
    console_monitor_mode_in |-> !stat_in[`ATSP_B_RDY] && !irq_lvl12_out;
  endproperty
  a_mon_hide: assert property (p_mon_hide) else $error("avail shown in monitor");
  property p_err_or;
    stat_in[`ATSP_B_ERR] == (|stat_in[7:5]);
  endproperty
  a_err_or: assert property (p_err_or) else $error("error or wrong");
  property p_zero_bits;
    stat_in[2:1] == 2'b00 && stat_in[15:8] == 8'h00 && stat_out[15:4] == 12'h000;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bit set");
  property p_irq;
    irq_lvl12_out == (avail_r && !console_monitor_mode_in && ie_in_r)
      && irq_lvl10_out == (!full_r && ie_out_r);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_autostart;
    s_load |=> full_r ##1 !full_r && !tx_ready ##1 !txd_out;
  endproperty
  a_autostart: assert property (p_autostart) else $error("no auto start");
  property p_overrun;
    rx_done && avail_r && !rd_data |=> ovr_r && stat_in[`ATSP_B_ERR];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");
  property p_loop;
    test_mode_group_in |-> rx_line == txd_out;
  endproperty
  a_loop: assert property (p_loop) else $error("group test not looped");
endmodule

//--- atsp_params.svh
// Purpose: constants of the async terminal serial port
// Assumes: 125 MHz system clock
// Notes: offsets are the low three bits of the device number
`ifndef ATSP_PARAMS_SVH
`define ATSP_PARAMS_SVH
`define ATSP_OFF_RX_DATA 3'h0
`define ATSP_OFF_RATE 3'h1
`define ATSP_OFF_IN_STAT 3'h2
`define ATSP_OFF_IN_CTRL 3'h3
`define ATSP_OFF_ZERO 3'h4
`define ATSP_OFF_TX_DATA 3'h5
`define ATSP_OFF_OUT_STAT 3'h6
`define ATSP_OFF_OUT_CTRL 3'h7
`define ATSP_B_IE 0
`define ATSP_B_TEST 3
`define ATSP_B_RDY 3
`define ATSP_B_ERR 4
`define ATSP_B_FRM 5
`define ATSP_B_PAR 6
`define ATSP_B_OVR 7
`define ATSP_B_LEN_LO 11
`define ATSP_B_LEN_HI 12
`define ATSP_B_STOP1 13
`define ATSP_B_PAR_EN 14
`define ATSP_CTRL_RST 16'h0000
`define ATSP_CLK_HZ 125000000
`define ATSP_BAUD 9600
`define ATSP_BIT_CYCLES (`ATSP_CLK_HZ / `ATSP_BAUD)
`endif

//--- atsp_pkg.sv
// Purpose: types of the async terminal serial port
// Assumes: nothing
// Notes: state encodings are left to the tools
package atsp_pkg;
  typedef enum {TX_IDLE, TX_SEND} atsp_tx_st_t;
  typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP} atsp_rx_st_t;
  typedef logic [1:0] atsp_len_t;
endpackage

//--- atsp_cfg_if.sv
// Purpose: character format shared by both channels
// Assumes: driven from the input control word
// Notes: len 0..3 means 8..5 data bits
`timescale 1ns/100ps
interface atsp_cfg_if;
  import atsp_pkg::*;
  atsp_len_t len; // character length code
  logic stop1; // one stop bit
  logic par_en; // even parity on
  modport src (output len, output stop1, output par_en);
  modport dst (input len, input stop1, input par_en);
endinterface

//--- atsp_tx.sv
// Purpose: serial transmitter of one character frame
// Assumes: half-bit timing, line idles high
// Notes: stop time counted in halves for the 1.5 case
`timescale 1ns/100ps
module atsp_tx #(
  parameter int HALF = 6510
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  atsp_cfg_if.dst cfg,
  input wire logic valid_in,
  input wire logic [7:0] data_in,
  output logic ready_out,
  output logic txd_out
);
  import atsp_pkg::*;
  atsp_tx_st_t st_r, st_nxt; // sender state
  logic [11:0] sh_r, sh_nxt; // frame, lsb on the line
  logic [4:0] halves_r, halves_nxt; // half bits left
  logic [15:0] tim_r, tim_nxt; // half-bit timer
  logic ph_r, ph_nxt; // second half of a bit
  logic [3:0] nb; // data bit count
  logic [4:0] stop_h; // stop length in halves
  logic par; // even parity bit
  // next state: frame build on accept, shift per bit
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    halves_nxt = halves_r;
    tim_nxt = tim_r;
    ph_nxt = ph_r;
    nb = 4'd8 - {2'b00, cfg.len};
    par = ^(data_in & ~(8'hff << nb));
    stop_h = cfg.stop1 ? 5'd2 : ((nb == 4'd5) ? 5'd3 : 5'd4);
    case (st_r)
      TX_IDLE: begin
        if (valid_in) begin
          // start automatically on load
          st_nxt = TX_SEND;
          sh_nxt = 12'hfff;
          sh_nxt[0] = 1'b0;
          for (int i = 0; i < 8; i++) begin
            if (i < int'(nb)) sh_nxt[i + 1] = data_in[i];
          end
          if (cfg.par_en) sh_nxt[nb + 4'd1] = par;
          halves_nxt = 5'((nb + 4'(cfg.par_en) + 4'd1) * 2) + stop_h;
          tim_nxt = 16'(HALF - 1);
          ph_nxt = 1'b0;
        end
      end
      TX_SEND: begin
        if (tim_r == 16'h0000) begin
          tim_nxt = 16'(HALF - 1);
          halves_nxt = halves_r - 5'd1;
          ph_nxt = ~ph_r;
          if (ph_r) sh_nxt = {1'b1, sh_r[11:1]};
          if (halves_r == 5'd1) st_nxt = TX_IDLE;
        end else begin
          tim_nxt = tim_r - 16'h0001;
        end
      end
      default: st_nxt = TX_IDLE;
    endcase
  end
  // registers only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= TX_IDLE;
      sh_r <= 12'hfff;
      halves_r <= 5'h00;
      tim_r <= 16'h0000;
      ph_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      halves_r <= halves_nxt;
      tim_r <= tim_nxt;
      ph_r <= ph_nxt;
    end
  end
  assign ready_out = (st_r == TX_IDLE);
  assign txd_out = (st_r == TX_SEND) ? sh_r[0] : 1'b1;
endmodule

//--- atsp_rx.sv
// Purpose: serial receiver, mid-bit sampling
// Assumes: line synchronous to clk_in
// Notes: a start bit shorter than half a bit is dropped
`timescale 1ns/100ps
module atsp_rx #(
  parameter int HALF = 6510,
  parameter int FULL = 13020
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  atsp_cfg_if.dst cfg,
  input wire logic rxd_in,
  output logic done_out,
  output logic [7:0] data_out,
  output logic frm_err_out,
  output logic par_err_out
);
  import atsp_pkg::*;
  atsp_rx_st_t st_r, st_nxt; // receiver state
  logic [15:0] tim_r, tim_nxt; // bit timer
  logic [3:0] idx_r, idx_nxt; // bit index
  logic [8:0] bits_r, bits_nxt; // data plus parity
  logic done_r, done_nxt;
  logic [7:0] data_r, data_nxt;
  logic frm_r, frm_nxt;
  logic par_r, par_nxt;
  logic [3:0] nb; // data bits
  logic [3:0] nt; // data plus parity bits
  // next state: always armed, no software start
  always_comb begin
    st_nxt = st_r;
    tim_nxt = tim_r;
    idx_nxt = idx_r;
    bits_nxt = bits_r;
    done_nxt = 1'b0;
    data_nxt = data_r;
    frm_nxt = frm_r;
    par_nxt = par_r;
    nb = 4'd8 - {2'b00, cfg.len};
    nt = nb + {3'b000, cfg.par_en};
    case (st_r)
      RX_IDLE: begin
        if (!rxd_in) begin
          st_nxt = RX_START;
          tim_nxt = 16'(HALF - 1);
        end
      end
      RX_START: begin
        if (tim_r != 16'h0000) begin
          tim_nxt = tim_r - 16'h0001;
        end else if (rxd_in) begin
          st_nxt = RX_IDLE; // false start
        end else begin
          st_nxt = RX_BITS;
          tim_nxt = 16'(FULL - 1);
          idx_nxt = 4'h0;
          bits_nxt = 9'h000;
        end
      end
      RX_BITS: begin
        if (tim_r != 16'h0000) begin
          tim_nxt = tim_r - 16'h0001;
        end else begin
          bits_nxt[idx_r] = rxd_in;
          idx_nxt = idx_r + 4'h1;
          tim_nxt = 16'(FULL - 1);
          if (idx_r == nt - 4'h1) st_nxt = RX_STOP;
        end
      end
      RX_STOP: begin
        if (tim_r != 16'h0000) begin
          tim_nxt = tim_r - 16'h0001;
        end else begin
          st_nxt = RX_IDLE;
          done_nxt = 1'b1;
          data_nxt = bits_r[7:0] & ~(8'hff << nb);
          par_nxt = cfg.par_en & (^(bits_r & ~(9'h1ff << nt)));
          frm_nxt = ~rxd_in;
        end
      end
      default: st_nxt = RX_IDLE;
    endcase
  end
  // registers only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= RX_IDLE;
      tim_r <= 16'h0000;
      idx_r <= 4'h0;
      bits_r <= 9'h000;
      done_r <= 1'b0;
      data_r <= 8'h00;
      frm_r <= 1'b0;
      par_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tim_r <= tim_nxt;
      idx_r <= idx_nxt;
      bits_r <= bits_nxt;
      done_r <= done_nxt;
      data_r <= data_nxt;
      frm_r <= frm_nxt;
      par_r <= par_nxt;
    end
  end
  assign done_out = done_r;
  assign data_out = data_r;
  assign frm_err_out = frm_r;
  assign par_err_out = par_r;
endmodule

//--- atsp_term_model.sv
// Purpose: serial terminal on the far end of the line
// Assumes: bit time of BC clocks, line idles high (mark)
// Notes: frames are sent and captured only when the bench asks
`timescale 1ns/100ps
module atsp_term_model #(
  parameter int BC = 16
) (
  input wire logic clk_in,
  input wire logic txd_in,
  output logic rxd_out
);
  int cyc = 0; // free cycle count, used to time frame starts
  initial rxd_out = 1'b1;
  // cycle counter
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
  end
  // start bit, then nb bits lsb first; stop bits are part of bits
  task automatic send(input logic [10:0] bits, input int nb);
    @(posedge clk_in) #1 rxd_out = 1'b0;
    repeat (BC) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      #1 rxd_out = bits[i];
      repeat (BC) @(posedge clk_in);
    end
    // back to mark so a bad stop does not look like a new start
    #1 rxd_out = 1'b1;
  endtask
  // wait for a start edge, then sample nb bits at bit centres
  task automatic capture(input int nb, output logic [9:0] d, output int t);
    d = '0;
    @(posedge clk_in);
    while (txd_in !== 1'b0) @(posedge clk_in);
    t = cyc;
    repeat (BC / 2) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      repeat (BC) @(posedge clk_in);
      d[i] = txd_in;
    end
  endtask
endmodule

//--- atsp_tb.sv
// Purpose: self-checking bench of the async terminal serial port
// Assumes: short bit time of 16 clocks, terminal model on the line
// Notes: register reads answer one cycle after the strobe
`timescale 1ns/100ps
module testbench;
  localparam int BC = 16;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] addr = 3'h0; // register offset
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic mon = 1'b0; // console monitor mode
  logic grp = 1'b0; // test request from sibling lines
  logic test_mode, txd, rxd, irq12, irq10;
  logic [7:0] ident;
  int miscompares = 0;
  int total_checks = 0;
  atsp_top #(.BIT_CYCLES(BC), .IDENT_CODE(8'h5c)) atsp_top_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .iox_addr_in(addr), .iox_rd_in(rd),
    .iox_wr_in(wr), .iox_wdata_in(wdata), .iox_rdata_out(rdata),
    .console_monitor_mode_in(mon), .test_mode_group_in(grp),
    .test_mode_out(test_mode), .rxd_in(rxd), .txd_out(txd),
    .irq_lvl12_out(irq12), .irq_lvl10_out(irq10), .ident_code_out(ident));
  atsp_term_model #(.BC(BC)) atsp_term_model_i (
    .clk_in(clk_in), .txd_in(txd), .rxd_out(rxd));
  // 125 MHz clock
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_in) #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk_in) #1 wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_in) #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk_in) #1 rd = 1'b0;
    d = rdata;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask
  // bounded wait for a received character
  task automatic wait_rx;
    for (int i = 0; i < 400 && irq12 !== 1'b1; i++) @(posedge clk_in);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog: whole run needs well under 10000 clocks
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    logic [15:0] d;
    logic [9:0] f;
    logic [9:0] e;
    int t0, t1, n, p, s1, gap;
    repeat (16) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    chk({14'h0000, irq12, irq10}, 16'h0000);
    chk({8'h00, ident}, 16'h005c);
    rchk(3'h2, 16'h0000);
    rchk(3'h6, 16'h0008);
    // write-only and spare offsets read as zero
    for (int i = 1; i < 8; i += 2) rchk(3'(i), 16'h0000);
    rchk(3'h4, 16'h0000);
    wr_reg(3'h7, 16'h0001);
    rchk(3'h6, 16'h0009);
    chk({15'h0000, irq10}, 16'h0001);
    // every length, parity on and off, both stop settings
    for (int k = 0; k < 8; k++) begin
      n = 8 - k % 4;
      p = k / 4;
      s1 = (k + p) % 2; // so 5 bits also meets the 1.5 stop case
      wr_reg(3'h3, 16'((p << 14) | (s1 << 13) | ((k % 4) << 11)));
      e = 10'(8'hb7 & ((1 << n) - 1));
      if (p == 1) e[n] = ^e;
      e[n + p] = 1'b1;
      fork
        begin
          atsp_term_model_i.capture(n + p + 1, f, t0);
          chk({6'h00, f}, {6'h00, e});
          atsp_term_model_i.capture(n + p + 1, f, t1);
        end
        begin
          wr_reg(3'h5, 16'h00b7);
          chk({15'h0000, irq10}, 16'h0000);
          d = 16'h0000;
          // the previous frame may still be in its stop bits: poll long enough
          for (int i = 0; i < 32 && d[3] !== 1'b1; i++) rd_reg(3'h6, d);
          chk(d, 16'h0009);
          wr_reg(3'h5, 16'h00b7);
          rchk(3'h6, 16'h0001);
        end
      join
      // frame length in half bits, stop of 1.5 only for 5 bits
      gap = 2 * (1 + n + p) + (s1 == 1 ? 2 : (n == 5 ? 3 : 4));
      chk(16'(t1 - t0 >= gap * BC / 2 && t1 - t0 <= gap * BC / 2 + 2), 16'h0001);
    end
    // receive 8N1 with interrupt on
    wr_reg(3'h3, 16'h2001);
    rchk(3'h2, 16'h0001);
    atsp_term_model_i.send(11'h1a5, 9);
    wait_rx();
    chk({15'h0000, irq12}, 16'h0001);
    rchk(3'h2, 16'h0009);
    rchk(3'h0, 16'h00a5);
    chk({15'h0000, irq12}, 16'h0000);
    rchk(3'h2, 16'h0001);
    // monitor mode hides the flag and keeps it over a read
    atsp_term_model_i.send(11'h15a, 9);
    wait_rx();
    mon = 1'b1;
    rchk(3'h2, 16'h0001);
    chk({15'h0000, irq12}, 16'h0000);
    rchk(3'h0, 16'h005a);
    mon = 1'b0;
    rchk(3'h2, 16'h0009);
    // overwrite an unread character
    atsp_term_model_i.send(11'h133, 9);
    rchk(3'h2, 16'h0099);
    rchk(3'h0, 16'h0033);
    rchk(3'h2, 16'h0001);
    // missing stop bit
    atsp_term_model_i.send(11'h0c3, 9);
    rchk(3'h2, 16'h0039);
    rd_reg(3'h0, d);
    // 7 bits, even parity, good then bad parity
    wr_reg(3'h3, 16'h6801);
    atsp_term_model_i.send(11'h135, 9);
    rchk(3'h2, 16'h0009);
    rchk(3'h0, 16'h0035);
    atsp_term_model_i.send(11'h1b5, 9);
    rchk(3'h2, 16'h0059);
    rd_reg(3'h0, d);
    // own test bit: loop back and still drive the line
    wr_reg(3'h3, 16'h2009);
    chk({15'h0000, test_mode}, 16'h0001);
    fork
      atsp_term_model_i.capture(9, f, t0);
      wr_reg(3'h5, 16'h00c6);
    join
    chk({6'h00, f}, 16'h01c6);
    wait_rx();
    rchk(3'h0, 16'h00c6);
    // test request from a sibling line
    wr_reg(3'h3, 16'h2001);
    grp = 1'b1;
    wr_reg(3'h5, 16'h003c);
    wait_rx();
    rchk(3'h0, 16'h003c);
    grp = 1'b0;
    report_and_stop();
  end
endmodule
